// ### design/port6_port7_pin_io.sv
// Pin logic of an 8-bit bidirectional port and an 8-bit input port.
// Assumes pins are synchronous to core_clk and the pad resolves the wire
// from pin_oe; timer, key-sense and converter logic live elsewhere.
//
// Our own choice: the plain strobed port.

// Operation
// - Pin 1 drives compare-A output when enabled, else direction bit decides.
// - Pins 2 and 3 follow direction; level always feeds capture and key sense.
// - Pin 0 feeds timer external clock only when clock select picks it.
// - Each pin has its own software pull-up enable bit.
// - Pull-up on only when enable is 1 and direction is 0.
// - Reset and hardware standby clear all pull-up enables, pull-ups off.
// - Software standby keeps pull-up enables and pull-up states unchanged.
// - Pull-up behaviour is the same in operating modes 1, 2 and 3.
// - Input port has no direction register and is input only.
// - Reading the input-port register returns current pin levels.
// - Writes to the input-port register have no effect.
// - Port read gives latch when direction is 1, pin level when 0.
// - Output latch clears on reset and hardware standby, holds in software standby.
module port6_port7_pin_io (
    // Clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      sys_rst,
    // Power state
    input  wire logic                      hw_standby,
    input  wire logic                      sw_standby,
    // Register port
    input  wire gpio_port_pkg::reg_req_t   reg_req,
    output logic      [7:0]                rd_data,
    // Bidirectional port pins
    input  wire logic [7:0]                bidir_pin_in,
    output logic      [7:0]                bidir_pin_out,
    output logic      [7:0]                bidir_pin_oe,
    output logic      [7:0]                bidir_pullup_on,
    // Dedicated input port pins
    input  wire logic [7:0]                input_pins,
    // Timer and key-sense connections
    input  wire gpio_port_pkg::timer_ctl_t timer_ctl,
    output gpio_port_pkg::timer_in_t       timer_in,
    output logic      [7:0]                key_sense_input
);

    // ------------------------------------------------------------
    // Power mode tracking
    // ------------------------------------------------------------
    gpio_port_pkg::power_mode_t mode;
    gpio_port_pkg::power_mode_t next_mode;
    logic                       clear;

    // Hardware standby dominates software standby
    always_comb begin
        if (hw_standby) begin
            next_mode = gpio_port_pkg::MODE_HW_STANDBY;
        end else if (sw_standby) begin
            next_mode = gpio_port_pkg::MODE_SW_STANDBY;
        end else begin
            next_mode = gpio_port_pkg::MODE_RUN;
        end
    end

    // Mode register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mode <= gpio_port_pkg::MODE_RUN;
        end else begin
            mode <= next_mode;
        end
    end

    // Same clear in every operating mode; software standby is no clear
    assign clear = sys_rst | hw_standby;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic [7:0] bidir_port_direction_bits;
    logic [7:0] bidir_port_output_latch;
    logic [7:0] bidir_port_pullup_enables;
    logic       wr_direction;
    logic       wr_latch;
    logic       wr_pullup;
    logic       writes_open;

    // Writes are refused while held in hardware standby
    assign writes_open = reg_req.wr & (mode != gpio_port_pkg::MODE_HW_STANDBY);

    // Write strobes per register; the input-port address has none
    always_comb begin
        wr_direction = 1'b0;
        wr_latch     = 1'b0;
        wr_pullup    = 1'b0;
        if (reg_req.addr == gpio_port_pkg::ADDR_DIRECTION) begin
            wr_direction = writes_open;
        end else if (reg_req.addr == gpio_port_pkg::ADDR_LATCH) begin
            wr_latch = writes_open;
        end else if (reg_req.addr == gpio_port_pkg::ADDR_PULLUP) begin
            wr_pullup = writes_open;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    port_reg8 #(
        .RESET_VALUE (gpio_port_pkg::RST_DIRECTION)
    ) u_direction (
        .core_clk   (core_clk),
        .clear      (clear),
        .write_en   (wr_direction),
        .write_data (reg_req.wdata),
        .value      (bidir_port_direction_bits)
    );

    port_reg8 #(
        .RESET_VALUE (gpio_port_pkg::RST_LATCH)
    ) u_latch (
        .core_clk   (core_clk),
        .clear      (clear),
        .write_en   (wr_latch),
        .write_data (reg_req.wdata),
        .value      (bidir_port_output_latch)
    );

    port_reg8 #(
        .RESET_VALUE (gpio_port_pkg::RST_PULLUP)
    ) u_pullup (
        .core_clk   (core_clk),
        .clear      (clear),
        .write_en   (wr_pullup),
        .write_data (reg_req.wdata),
        .value      (bidir_port_pullup_enables)
    );

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [7:0] bidir_read_value;

    // Latch for outputs, live pin for inputs
    assign bidir_read_value = (bidir_port_direction_bits & bidir_port_output_latch)
                            | (~bidir_port_direction_bits & bidir_pin_in);

    // Read data stand for one cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_data <= gpio_port_pkg::READ_UNMAPPED;
        end else if (!reg_req.rd) begin
            rd_data <= gpio_port_pkg::READ_UNMAPPED;
        end else if (reg_req.addr == gpio_port_pkg::ADDR_INPUT) begin
            rd_data <= input_pins;
        end else if (reg_req.addr == gpio_port_pkg::ADDR_LATCH) begin
            rd_data <= bidir_read_value;
        end else if (reg_req.addr == gpio_port_pkg::ADDR_DIRECTION) begin
            rd_data <= bidir_port_direction_bits;
        end else if (reg_req.addr == gpio_port_pkg::ADDR_PULLUP) begin
            rd_data <= bidir_port_pullup_enables;
        end else begin
            rd_data <= gpio_port_pkg::READ_UNMAPPED;
        end
    end

    // Input port: pins only, no direction or drive logic at all

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    logic [7:0] alt_enable;
    logic [7:0] alt_value;

    // Only pin 1 carries a timer output
    always_comb begin
        alt_enable = 8'h00;
        alt_value  = 8'h00;
        alt_enable[gpio_port_pkg::PIN_COMPARE_A] = timer_ctl.compare_a_output_enable;
        alt_value[gpio_port_pkg::PIN_COMPARE_A]  = timer_ctl.timer_compare_a_out;
    end

    // One cell per bidirectional pin
    for (genvar i = 0; i < 8; i++) begin : g_pin
        bidir_pin_cell u_cell (
            .core_clk      (core_clk),
            .clear         (clear),
            .direction     (bidir_port_direction_bits[i]),
            .latch_bit     (bidir_port_output_latch[i]),
            .pullup_enable (bidir_port_pullup_enables[i]),
            .alt_enable    (alt_enable[i]),
            .alt_value     (alt_value[i]),
            .pin_out       (bidir_pin_out[i]),
            .pin_oe        (bidir_pin_oe[i]),
            .pullup_on     (bidir_pullup_on[i])
        );
    end

    // ------------------------------------------------------------
    // Inputs to timer and key sense
    // ------------------------------------------------------------
    logic ext_clock_selected;

    assign ext_clock_selected = ({timer_ctl.timer_clock_select_hi, timer_ctl.timer_clock_select_lo}
                                 == gpio_port_pkg::CLOCK_SELECT_EXTERNAL);

    // Pin levels feed the timer in both directions
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            timer_in <= '0;
        end else begin
            timer_in.timer_capture_a_in      <= bidir_pin_in[gpio_port_pkg::PIN_CAPTURE_A];
            timer_in.timer_capture_b_in      <= bidir_pin_in[gpio_port_pkg::PIN_CAPTURE_B];
            timer_in.timer_external_clock_in <= ext_clock_selected
                                              & bidir_pin_in[gpio_port_pkg::PIN_EXT_CLOCK];
        end
    end

    // Key-sense sees every pin level
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            key_sense_input <= 8'h00;
        end else begin
            key_sense_input <= bidir_pin_in;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_cmpa_override: assert property (
        timer_ctl.compare_a_output_enable && !hw_standby
        |=> bidir_pin_oe[1] && bidir_pin_out[1] == $past(timer_ctl.timer_compare_a_out))
        else $error("compare-A output not driven on pin 1");

    a_gpio_direction: assert property (
        !hw_standby |=> bidir_pin_oe[3:2] == $past(bidir_port_direction_bits[3:2]))
        else $error("pin 2 or 3 drive does not follow direction");

    a_capture_feed: assert property (
        ##1 timer_in.timer_capture_a_in == $past(bidir_pin_in[2])
            && timer_in.timer_capture_b_in == $past(bidir_pin_in[3]))
        else $error("capture input does not follow pin level");

    a_ext_clock_gate: assert property (
        !ext_clock_selected |=> !timer_in.timer_external_clock_in)
        else $error("external clock passed while not selected");

    a_pullup_gating: assert property (
        !hw_standby |=> bidir_pullup_on
                        == $past(bidir_port_pullup_enables & ~bidir_port_direction_bits))
        else $error("pull-up state wrong for enable and direction");

    a_standby_clear: assert property (
        hw_standby |=> bidir_pullup_on == 8'h00 ##1 bidir_port_pullup_enables == 8'h00)
        else $error("hardware standby left a pull-up on");

    a_sw_standby_hold: assert property (
        sw_standby && !hw_standby && !reg_req.wr
        |=> $stable(bidir_port_pullup_enables) && $stable(bidir_port_output_latch))
        else $error("software standby changed port state");

    a_input_read: assert property (
        reg_req.rd && reg_req.addr == gpio_port_pkg::ADDR_INPUT |=> rd_data == $past(input_pins))
        else $error("input port read is not the pin level");

    a_input_no_write: assert property (
        reg_req.wr && reg_req.addr == gpio_port_pkg::ADDR_INPUT && !hw_standby
        |=> $stable(bidir_port_direction_bits) && $stable(bidir_port_output_latch)
            && $stable(bidir_port_pullup_enables))
        else $error("write to input port changed a register");

    a_bidir_read: assert property (
        reg_req.rd && reg_req.addr == gpio_port_pkg::ADDR_LATCH |=> rd_data == $past(bidir_read_value))
        else $error("port read mixes latch and pin wrongly");

    a_latch_clear: assert property (
        hw_standby |=> bidir_port_output_latch == 8'h00)
        else $error("output latch not cleared in hardware standby");

    c_pullup_active: cover property (wr_pullup ##1 !wr_direction ##1 bidir_pullup_on != 8'h00);
    c_cmpa_drive: cover property (timer_ctl.compare_a_output_enable ##1 bidir_pin_oe[1]);
    c_sw_standby: cover property (mode == gpio_port_pkg::MODE_SW_STANDBY && bidir_pullup_on != 8'h00);
    c_input_read: cover property (reg_req.rd && reg_req.addr == gpio_port_pkg::ADDR_INPUT);

endmodule : port6_port7_pin_io

// ### design/gpio_port_pkg.sv
// Constants and carrier types for the port pin logic.
// Assumes a byte-wide register port and pins synchronous to core_clk.
package gpio_port_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_DIRECTION = 16'hFFB9;  // Bidirectional port direction bits
    localparam logic [15:0] ADDR_LATCH     = 16'hFFBB;  // Bidirectional port output latch
    localparam logic [15:0] ADDR_PULLUP    = 16'hFFAC;  // Bidirectional port pull-up enables
    localparam logic [15:0] ADDR_INPUT     = 16'hFFBE;  // Dedicated input port pin levels

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic [7:0] RST_LATCH     = 8'h00;
    localparam logic [7:0] RST_PULLUP    = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ------------------------------------------------------------
    // Pin positions of the timer functions
    // ------------------------------------------------------------
    localparam int PIN_EXT_CLOCK = 0;
    localparam int PIN_COMPARE_A = 1;
    localparam int PIN_CAPTURE_A = 2;
    localparam int PIN_CAPTURE_B = 3;

    // Clock-select code that picks the external clock source
    localparam logic [1:0] CLOCK_SELECT_EXTERNAL = 2'h3;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic compare_a_output_enable;
        logic timer_compare_a_out;
        logic timer_clock_select_hi;
        logic timer_clock_select_lo;
    } timer_ctl_t;

    typedef struct packed {
        logic timer_capture_a_in;
        logic timer_capture_b_in;
        logic timer_external_clock_in;
    } timer_in_t;

    typedef enum logic [2:0] {
        MODE_RUN        = 3'h1,
        MODE_SW_STANDBY = 3'h2,
        MODE_HW_STANDBY = 3'h4
    } power_mode_t;

endpackage : gpio_port_pkg

// ### design/port_reg8.sv
// One byte-wide software register with a clear input.
// Assumes clear is already the OR of reset and hardware standby.
module port_reg8 #(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    // Clock and clear
    input  wire logic       core_clk,
    input  wire logic       clear,
    // Write side
    input  wire logic       write_en,
    input  wire logic [7:0] write_data,
    // Stored value
    output logic      [7:0] value
);

    // Clear wins over a write; otherwise hold
    always_ff @(posedge core_clk) begin
        if (clear) begin
            value <= RESET_VALUE;
        end else if (write_en) begin
            value <= write_data;
        end
    end

endmodule : port_reg8

// ### design/bidir_pin_cell.sv
// Output driver and pull-up control for one bidirectional pin.
// Assumes the alternate drive request comes from an on-chip timer.
module bidir_pin_cell (
    // Clock and clear
    input  wire logic core_clk,
    input  wire logic clear,
    // Control
    input  wire logic direction,
    input  wire logic latch_bit,
    input  wire logic pullup_enable,
    input  wire logic alt_enable,
    input  wire logic alt_value,
    // Pin side
    output logic      pin_out,
    output logic      pin_oe,
    output logic      pullup_on
);

    // Alternate function overrides the direction bit
    always_ff @(posedge core_clk) begin
        if (clear) begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end else begin
            pin_oe  <= alt_enable | direction;
            pin_out <= alt_enable ? alt_value : latch_bit;
        end
    end

    // Pull-up only for an enabled pin with direction 0, even under alternate drive; never under clear
    always_ff @(posedge core_clk) begin
        if (clear) begin
            pullup_on <= 1'b0;
        end else begin
            pullup_on <= pullup_enable & ~direction & ~clear;
        end
    end

endmodule : bidir_pin_cell

// ### verification/pin_pad_model.sv
// Pad and board model for the eight bidirectional port pins.
// Assumes registered drive, enable and pull-up controls from the block.
module pin_pad_model (
    // Clock
    input  wire logic       core_clk,
    // Block side
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pullup_on,
    // Off-chip drivers
    input  wire logic [7:0] ext_oe,
    input  wire logic [7:0] ext_val,
    // Resolved wire
    output logic      [7:0] wire_level
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] float_pat = 8'h55;

    // Undriven line without pull-up wanders every cycle
    always_ff @(posedge core_clk) begin
        float_pat <= ~float_pat;
    end

    // Wire resolution per pin
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) begin
                wire_level[i] = pin_out[i];
            end else if (ext_oe[i]) begin
                wire_level[i] = ext_val[i];
            end else if (pullup_on[i]) begin
                wire_level[i] = 1'b1;
            end else begin
                wire_level[i] = float_pat[i];
            end
        end
    end
endmodule : pin_pad_model

// ### verification/port6_port7_pin_io_tb.sv
// Self-checking bench for the port pin logic.
// Assumes the pad model resolves the bidirectional wires.
module port6_port7_pin_io_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                      core_clk, sys_rst, hw_standby, sw_standby;
    gpio_port_pkg::reg_req_t   reg_req;
    gpio_port_pkg::timer_ctl_t timer_ctl;
    gpio_port_pkg::timer_in_t  timer_in;
    logic [7:0]                rd_data, pin_in, pin_out, pin_oe, pull_on, input_pins, key_in, ext_oe, ext_val, rd_val;
    int                        fail_count, checked, cycles;

    port6_port7_pin_io i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .hw_standby(hw_standby),
        .sw_standby(sw_standby), .reg_req(reg_req), .rd_data(rd_data), .bidir_pin_in(pin_in),
        .bidir_pin_out(pin_out), .bidir_pin_oe(pin_oe), .bidir_pullup_on(pull_on), .input_pins(input_pins),
        .timer_ctl(timer_ctl), .timer_in(timer_in), .key_sense_input(key_in));
    pin_pad_model i_pads (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pull_on),
        .ext_oe(ext_oe), .ext_val(ext_val), .wire_level(pin_in));

    // ------------------------------------------------------------
    // Clock and cycle ceiling
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        reg_req.wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [15:0] a);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        reg_req.rd <= 1'b0;
        #1;
        rd_val = rd_data;
    endtask : reg_rd

    task automatic setup(input logic [7:0] dir, input logic [7:0] lat, input logic [7:0] pu);
        reg_wr(gpio_port_pkg::ADDR_DIRECTION, dir);
        reg_wr(gpio_port_pkg::ADDR_LATCH, lat);
        reg_wr(gpio_port_pkg::ADDR_PULLUP, pu);
        settle(3);
    endtask : setup

    task automatic set_timer(input logic en, input logic val, input logic [1:0] sel);
        @(posedge core_clk);
        timer_ctl <= '{compare_a_output_enable: en, timer_compare_a_out: val,
                       timer_clock_select_hi: sel[1], timer_clock_select_lo: sel[0]};
        settle(3);
    endtask : set_timer

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset_values();
        reg_rd(gpio_port_pkg::ADDR_DIRECTION);
        check(rd_val, 8'h00);
        reg_rd(gpio_port_pkg::ADDR_PULLUP);
        check(rd_val, 8'h00);
        check(pull_on, 8'h00);
        check(pin_oe, 8'h00);
        $display("test reset_values done");
    endtask : test_reset_values

    task automatic test_pullup_and_read();
        setup(8'hF0, 8'h5A, 8'hA5);
        check(pull_on, 8'h05);
        reg_rd(gpio_port_pkg::ADDR_PULLUP);
        check(rd_val, 8'hA5);
        check(pin_oe, 8'hF0);
        check(pin_out, 8'h5A);
        reg_rd(gpio_port_pkg::ADDR_LATCH);
        check(rd_val, 8'h53);
        $display("test pullup_and_read done");
    endtask : test_pullup_and_read

    task automatic test_compare_a();
        setup(8'h00, 8'h00, 8'hFF);
        set_timer(1'b1, 1'b1, 2'h0);
        check({5'h00, pin_oe[1], pin_out[1], pull_on[1]}, 8'h07);
        set_timer(1'b1, 1'b0, 2'h0);
        check({6'h00, pin_oe[1], pin_out[1]}, 8'h02);
        set_timer(1'b0, 1'b1, 2'h0);
        check(pin_oe, 8'h00);
        setup(8'h02, 8'h02, 8'hFF);
        check({5'h00, pin_oe[1], pin_out[1], pull_on[1]}, 8'h06);
        $display("test compare_a done");
    endtask : test_compare_a

    task automatic test_timer_key();
        @(posedge core_clk);
        ext_oe <= 8'hF3;
        ext_val <= 8'hA1;
        setup(8'h0C, 8'h04, 8'h00);
        check(key_in, 8'hA5);
        for (int s = 0; s < 4; s++) begin
            set_timer(1'b0, 1'b0, s[1:0]);
            check({5'h00, timer_in}, {5'h00, 2'b10, (s == 3)});
        end
        $display("test timer_key done");
    endtask : test_timer_key

    task automatic test_input_port();
        logic [7:0] vals [4] = '{8'h3C, 8'hC3, 8'h00, 8'hFF};
        foreach (vals[i]) begin
            @(posedge core_clk);
            input_pins <= vals[i];
            reg_rd(gpio_port_pkg::ADDR_INPUT);
            check(rd_val, vals[i]);
        end
        reg_wr(gpio_port_pkg::ADDR_INPUT, 8'h5A);
        reg_rd(gpio_port_pkg::ADDR_INPUT);
        check(rd_val, 8'hFF);
        reg_rd(gpio_port_pkg::ADDR_DIRECTION);
        check(rd_val, 8'h0C);
        reg_wr(16'hFFB0, 8'h77);
        reg_rd(16'hFFB0);
        check(rd_val, 8'h00);
        $display("test input_port done");
    endtask : test_input_port

    task automatic test_standby();
        @(posedge core_clk);
        ext_oe <= 8'hCF;
        ext_val <= 8'h00;
        setup(8'h30, 8'h30, 8'h0F);
        @(posedge core_clk);
        sw_standby <= 1'b1;
        settle(3);
        check(pull_on, 8'h0F);
        reg_rd(gpio_port_pkg::ADDR_LATCH);
        check(rd_val, 8'h30);
        @(posedge core_clk);
        sw_standby <= 1'b0;
        hw_standby <= 1'b1;
        settle(3);
        check(pull_on, 8'h00);
        check(pin_oe, 8'h00);
        check(pin_out, 8'h00);
        reg_wr(gpio_port_pkg::ADDR_PULLUP, 8'hFF);
        @(posedge core_clk);
        hw_standby <= 1'b0;
        settle(3);
        reg_rd(gpio_port_pkg::ADDR_PULLUP);
        check(rd_val, 8'h00);
        check(pull_on, 8'h00);
        $display("test standby done");
    endtask : test_standby

    task automatic test_mid_reset();
        setup(8'h00, 8'hFF, 8'hFF);
        check(pull_on, 8'hFF);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        settle(2);
        check(pull_on, 8'h00);
        @(posedge core_clk);
        sys_rst <= 1'b0;
        reg_rd(gpio_port_pkg::ADDR_PULLUP);
        check(rd_val, 8'h00);
        $display("test mid_reset done");
    endtask : test_mid_reset

    // ------------------------------------------------------------
    // Verdict
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    // Main sequence
    initial begin
        sys_rst = 1'b1;
        hw_standby = 1'b0;
        sw_standby = 1'b0;
        reg_req = '0;
        timer_ctl = '0;
        input_pins = 8'h00;
        ext_oe = 8'h0F;
        ext_val = 8'h03;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        test_reset_values();
        test_pullup_and_read();
        test_compare_a();
        test_timer_key();
        test_input_port();
        test_standby();
        test_mid_reset();
        wrap_up();
    end
endmodule : port6_port7_pin_io_tb
